// File: core/usb_ep_regs.vh
// register indexes, field positions, reset values and codes of the endpoint block
// assumes: included by the endpoint logic; definitions only
`ifndef USB_EP_REGS_VH
`define USB_EP_REGS_VH

// ----------------------------------------------------------------------------
// register indexes (byte address on the bus is four times the index)
// ----------------------------------------------------------------------------
`define DEV_ADDR_IDX      8'h10
`define CTL_EP_COUNT_IDX  8'h11
`define CTL_EP_MODE_IDX   8'h12
`define EP1_COUNT_IDX     8'h13
`define FIRST_DATA_ENDPOINT_MODE_IDX      8'h14
`define EP2_COUNT_IDX     8'h15
`define SECOND_DATA_ENDPOINT_MODE_IDX      8'h16
`define FIFO_BASE_IDX     8'he8
`define FIFO_LAST_IDX     8'hff
`define CTL_EP_FIFO_OFF   5'h10
`define FIFO_DEPTH        24

// ----------------------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------------------
`define REG_RESET         8'h00
`define ADDR_EN_BIT       7
`define SETUP_RX_BIT      7
`define IN_RX_BIT         6
`define OUT_RX_BIT        5
`define ACKED_BIT         4
`define STALL_BIT         7
`define TOGGLE_BIT        7
`define VALID_BIT         6
`define CRC_BYTES         4'h2

// ----------------------------------------------------------------------------
// token kinds, handshake answers, mode codes
// ----------------------------------------------------------------------------
`define PID_SETUP         2'h0
`define PID_IN            2'h1
`define PID_OUT           2'h2
`define RESP_NONE         2'h0
`define RESP_ACK          2'h1
`define RESP_NAK          2'h2
`define RESP_STALL        2'h3
`define MODE_DISABLED     4'h0
`define MODE_NAK_INOUT    4'h1
`define MODE_ACKOUT_NAKIN 4'hb
`define MODE_ACK_IN       4'hf

`endif

// File: core/usb_endpoint_status_control.v
// endpoint mode, counter and address registers of a low-speed usb engine,
// with the three endpoint fifos, reached over a classic wishbone slave.
// assumes: the serial engine runs on mclk and gives one-cycle event pulses.
// assumes: firmware reads a locked control register before it rewrites it.
//
// Design decision made here: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "usb_ep_regs.vh"

// Overview of operation
// - control endpoint fifo is bytes 0xF8-0xFF
// - engine update locks control mode until read
// - unlocked control mode write clears bits 7:4
// - setup flag held from setup data to ack
// - setup flag blocks cpu writes to control fifo
// - in-received set after valid control IN
// - out-received set after valid control OUT
// - acked bit set on ACK-completed transaction
// - mode 0001 naks IN/OUT, acks SETUP
// - mode 1011 becomes 0001 after acked OUT
// - data endpoint mode writes always take effect
// - data fifos at 0xF0-0xF7 and 0xE8-0xEF
// - stall bit stalls ack-out OUT, ack-in IN
// - data endpoint modes decode and update alike
// - counter bit 7 is data toggle
// - counter valid bit cleared on receive errors
// - received count is bytes plus two
// - OUT/SETUP update locks control count until read
// - engine answers only when address enabled
// - resets clear the device address register
module usb_endpoint_status_control (
  input  wire        mclk,
  input  wire        rst_b,
  // classic wishbone slave; data rides the low byte lane only
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [9:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // token decode from the serial engine; handshake in the same cycle, toggle and count one cycle later
  input  wire        usbBusReset,
  input  wire [6:0]  tokAddr,
  input  wire [1:0]  tokEp,
  input  wire [1:0]  tokPid,
  output wire        addrMatch,
  output wire [1:0]  respCode,
  output wire        inToggle,
  output wire [3:0]  inCount,
  // transaction events: one-cycle pulses with their status beside them
  input  wire        setupStart,
  input  wire        ackStart,
  input  wire        xferDone,
  input  wire [1:0]  doneEp,
  input  wire [1:0]  donePid,
  input  wire        doneAcked,
  input  wire        doneToggle,
  input  wire        doneErr,
  input  wire [3:0]  doneBytes,
  // engine side of the three endpoint fifos
  input  wire        sieFifoWe,
  input  wire [4:0]  sieFifoAddr,
  input  wire [7:0]  sieFifoWdata,
  output reg  [7:0]  sieFifoRdata
);

  // --------------------------------------------------------------------------
  // sizes
  // --------------------------------------------------------------------------
  // one control endpoint and two data endpoints; the register map has no
  // room for more, so this is not a parameter
  localparam NUM_EP = 3;

  // --------------------------------------------------------------------------
  // decode helpers
  // --------------------------------------------------------------------------
  // register index of an endpoint's mode and counter bytes
  function [7:0] modeIdx;
    input integer ep;
    begin
      case (ep)
        0:       modeIdx = `CTL_EP_MODE_IDX;
        1:       modeIdx = `FIRST_DATA_ENDPOINT_MODE_IDX;
        default: modeIdx = `SECOND_DATA_ENDPOINT_MODE_IDX;
      endcase
    end
  endfunction

  function [7:0] countIdx;
    input integer ep;
    begin
      case (ep)
        0:       countIdx = `CTL_EP_COUNT_IDX;
        1:       countIdx = `EP1_COUNT_IDX;
        default: countIdx = `EP2_COUNT_IDX;
      endcase
    end
  endfunction

  // handshake for a token, given the endpoint mode byte and whether
  // that endpoint has a stall bit at all
  // (the control endpoint has none, so its bit 7 stays the setup flag)
  function [1:0] handshake;
    input [7:0] mode;
    input       hasStall;
    input [1:0] pid;
    reg         stall;
    begin
      stall = hasStall & mode[`STALL_BIT];
      case (mode[3:0])
        // a disabled endpoint stays silent and the host times out
        `MODE_DISABLED:
          handshake = `RESP_NONE;
        `MODE_NAK_INOUT:
          handshake = (pid == `PID_SETUP) ? `RESP_ACK : `RESP_NAK;
        `MODE_ACKOUT_NAKIN: begin
          if (pid == `PID_SETUP)
            handshake = `RESP_ACK;
          else if (pid == `PID_OUT)
            handshake = stall ? `RESP_STALL : `RESP_ACK;
          else
            handshake = `RESP_NAK;
        end
        `MODE_ACK_IN: begin
          if (pid == `PID_SETUP)
            handshake = `RESP_ACK;
          else if (pid == `PID_IN)
            handshake = stall ? `RESP_STALL : `RESP_ACK;
          else
            handshake = `RESP_NAK;
        end
        // modes without their own entry NAK IN and OUT but still take SETUP
        default:
          handshake = (pid == `PID_SETUP) ? `RESP_ACK : `RESP_NAK;
      endcase
    end
  endfunction

  // --------------------------------------------------------------------------
  // bus decode
  // --------------------------------------------------------------------------
  // a raised ack masks the strobe so one request is never taken twice;
  // a write with the low lane off is acked and dropped
  wire       busReq  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire [7:0] adrIdx  = wb_adr_i[9:2];
  wire       busWr   = busReq & wb_we_i & wb_sel_i[0];
  wire       busRd   = busReq & ~wb_we_i;
  wire [7:0] wrData  = wb_dat_i[7:0];
  wire       inFifo  = (adrIdx >= `FIFO_BASE_IDX);
  wire [7:0] fifoOff = adrIdx - `FIFO_BASE_IDX;

  reg  [7:0] addrReg;
  reg        setupHold;
  reg        modeLock;
  reg        countLock;
  reg  [7:0] fifoMem [0:`FIFO_DEPTH-1];
  wire [23:0] modeFlat;
  wire [23:0] countFlat;
  reg        inToggle_reg;
  reg  [3:0] inCount_reg;
  // only three endpoints exist; a token to any other number is not ours
  wire       tokEpValid = (tokEp != 2'd3);

  // --------------------------------------------------------------------------
  // device address
  // --------------------------------------------------------------------------
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      addrReg <= `REG_RESET;
    end else if (usbBusReset) begin
      addrReg <= `REG_RESET;
    end else if (busWr && adrIdx == `DEV_ADDR_IDX) begin
      addrReg <= wrData;
    end
  end

  // a usb bus reset clears the address as a hardware reset does; the
  // engine sees no traffic as ours until the enable bit is set again
  assign addrMatch = addrReg[`ADDR_EN_BIT] & (tokAddr == addrReg[6:0]);
  // the handshake stays combinational: it is the answer to the token itself
  assign respCode  = (addrMatch & tokEpValid) ?
                     handshake(modeFlat[tokEp*8 +: 8], tokEp != 2'd0, tokPid) :
                     `RESP_NONE;
  assign inToggle  = inToggle_reg;
  assign inCount   = inCount_reg;

  // --------------------------------------------------------------------------
  // toggle and count of the endpoint under decode
  // --------------------------------------------------------------------------
  // registered so the transmit side sees a settled value; they lag the
  // token by one cycle, far less than the gap before the data packet
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      inToggle_reg <= 1'b0;
      inCount_reg  <= 4'h0;
    end else if (tokEpValid) begin
      inToggle_reg <= countFlat[tokEp*8 + `TOGGLE_BIT];
      inCount_reg  <= countFlat[tokEp*8 +: 4];
    end else begin
      inToggle_reg <= 1'b0;
      inCount_reg  <= 4'h0;
    end
  end

  // --------------------------------------------------------------------------
  // setup hold window and control endpoint locks
  // --------------------------------------------------------------------------
  // the locks keep firmware from overwriting status it has not yet read;
  // only a read lifts them, so firmware reads before it writes
  wire ctlDone   = xferDone & (doneEp == 2'd0);
  wire ctlRxDone = ctlDone & (donePid != `PID_IN);
  wire rdMode0   = busRd & (adrIdx == `CTL_EP_MODE_IDX);
  wire rdCount0  = busRd & (adrIdx == `CTL_EP_COUNT_IDX);

  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      setupHold <= 1'b0;
      modeLock  <= 1'b0;
      countLock <= 1'b0;
    end else begin
      // the setup window opens at the data packet and closes at our ack
      if (setupStart)
        setupHold <= 1'b1;
      else if (ackStart)
        setupHold <= 1'b0;
      // a fresh engine update wins over an unlocking read in the same cycle
      if (setupStart || ctlDone)
        modeLock <= 1'b1;
      else if (rdMode0)
        modeLock <= 1'b0;
      // only received data locks the count; an IN leaves it to firmware
      if (ctlRxDone)
        countLock <= 1'b1;
      else if (rdCount0)
        countLock <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // per-endpoint mode and counter registers
  // --------------------------------------------------------------------------
  genvar gi;
  generate
    // one copy per endpoint; only the control copy has locks and rx flags
    for (gi = 0; gi < NUM_EP; gi = gi + 1) begin : epRegs
      reg  [7:0] mode_reg;
      reg  [7:0] count_reg;
      reg  [7:0] mode_next;
      reg  [7:0] count_next;
      wire       isCtl   = (gi == 0);
      wire       hit     = xferDone & (doneEp == gi);
      wire       wrMode  = busWr & (adrIdx == modeIdx(gi)) & ~(isCtl & modeLock);
      wire       wrCount = busWr & (adrIdx == countIdx(gi)) & ~(isCtl & countLock);

      always @* begin
        mode_next  = mode_reg;
        count_next = count_reg;
        if (wrMode) begin
          if (isCtl)
            mode_next = {4'h0, wrData[3:0]};
          else
            // reserved bits forced low; acked bit only cleared by a zero
            mode_next = {wrData[7], 2'b00, mode_reg[4] & wrData[4], wrData[3:0]};
        end
        // counter bits 5:4 are reserved and always read zero
        if (wrCount)
          count_next = {wrData[7:6], 2'b00, wrData[3:0]};
        // engine events are applied last so a set beats a same-cycle clear
        if (isCtl && (setupStart || setupHold))
          mode_next[`SETUP_RX_BIT] = 1'b1;
        if (hit) begin
          if (doneAcked)
            mode_next[`ACKED_BIT] = 1'b1;
          if (isCtl && donePid == `PID_IN)
            mode_next[`IN_RX_BIT] = 1'b1;
          if (isCtl && donePid == `PID_OUT)
            mode_next[`OUT_RX_BIT] = 1'b1;
          if (doneAcked && donePid == `PID_OUT &&
              mode_reg[3:0] == `MODE_ACKOUT_NAKIN)
            mode_next[3:0] = `MODE_NAK_INOUT;
          if (donePid != `PID_IN) begin
            count_next[`TOGGLE_BIT] = doneToggle;
            count_next[`VALID_BIT]  = ~doneErr;
            count_next[5:4]         = 2'b00;
            count_next[3:0]         = doneBytes + `CRC_BYTES;
          end
        end
      end

      always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
          mode_reg  <= `REG_RESET;
          count_reg <= `REG_RESET;
        end else begin
          mode_reg  <= mode_next;
          count_reg <= count_next;
        end
      end

      // flattened so the bus read and token decode can pick any endpoint
      assign modeFlat[gi*8 +: 8]  = mode_reg;
      assign countFlat[gi*8 +: 8] = count_reg;
    end
  endgenerate

  // --------------------------------------------------------------------------
  // endpoint fifos: control at the top eight bytes, then first and second
  // --------------------------------------------------------------------------
  // fifo bytes are not reset; firmware fills a buffer before it arms it
  wire ctlFifoHit = fifoOff[4:0] >= `CTL_EP_FIFO_OFF;
  // while setup data is pending the cpu may not overwrite the control fifo
  wire cpuFifoWr  = busWr & inFifo &
                    ~(ctlFifoHit & modeFlat[`SETUP_RX_BIT]);
  // the engine address has 32 codes for 24 bytes; codes past the end write
  // nothing and read zero instead of an undefined word
  wire sieInRange = (sieFifoAddr < `FIFO_DEPTH);

  always @(posedge mclk) begin
    if (cpuFifoWr)
      fifoMem[fifoOff[4:0]] <= wrData;
    // engine store last: it wins a same-address collision
    if (sieFifoWe && sieInRange)
      fifoMem[sieFifoAddr] <= sieFifoWdata;
  end

  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b)
      sieFifoRdata <= 8'h00;
    else
      sieFifoRdata <= sieInRange ? fifoMem[sieFifoAddr] : 8'h00;
  end

  // --------------------------------------------------------------------------
  // wishbone answer: one wait state, unmapped reads return zero
  // --------------------------------------------------------------------------
  // every request is answered, mapped or not, so a master never hangs;
  // read data holds until the next read for a slow master
  reg [7:0] rdByte;

  always @* begin
    rdByte = 8'h00;
    // the fifo bytes sit above every register index
    if (inFifo)
      rdByte = fifoMem[fifoOff[4:0]];
    else begin
      case (adrIdx)
        `DEV_ADDR_IDX:     rdByte = addrReg;
        `CTL_EP_COUNT_IDX: rdByte = countFlat[7:0];
        `CTL_EP_MODE_IDX:  rdByte = modeFlat[7:0];
        `EP1_COUNT_IDX:    rdByte = countFlat[15:8];
        `FIRST_DATA_ENDPOINT_MODE_IDX:     rdByte = modeFlat[15:8];
        `EP2_COUNT_IDX:    rdByte = countFlat[23:16];
        `SECOND_DATA_ENDPOINT_MODE_IDX:     rdByte = modeFlat[23:16];
        default:           rdByte = 8'h00;
      endcase
    end
  end

  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= busReq;
      if (busRd)
        wb_dat_o <= {24'h000000, rdByte};
    end
  end

endmodule // usb_endpoint_status_control
`default_nettype wire

// File: test/usb_ep_monitor.sv
// port checks of the endpoint status block
// assumes: bound to usb_endpoint_status_control, one mclk domain
`timescale 1ns/1ps
`default_nettype none
`include "usb_ep_regs.vh"
module usb_ep_monitor (
  input wire logic        mclk,
  input wire logic        rst_b,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [9:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        usbBusReset,
  input wire logic [1:0]  tokEp,
  input wire logic        addrMatch,
  input wire logic [1:0]  respCode,
  input wire logic [3:0]  inCount,
  input wire logic        setupStart,
  input wire logic        ackStart,
  input wire logic        xferDone,
  input wire logic [1:0]  doneEp,
  input wire logic [1:0]  donePid,
  input wire logic [3:0]  doneBytes
);
  logic holdFlag;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // ----------
  // setup data seen, returned ack not yet started
  // ----------
  always_ff @(posedge mclk or negedge rst_b)
    if (!rst_b) holdFlag <= 1'b0;
    else if (setupStart) holdFlag <= 1'b1;
    else if (ackStart) holdFlag <= 1'b0;
  property p_ack_next; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack late");
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_ack_cause; $rose(wb_ack_o) |-> $past(wb_stb_i); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_addr_clear; usbBusReset |=> !addrMatch; endproperty
  a_addr_clear: assert property (p_addr_clear) else $error("address kept");
  property p_no_match; !addrMatch |-> respCode == `RESP_NONE; endproperty
  a_no_match: assert property (p_no_match) else $error("answer off address");
  property p_setup_hold; holdFlag && wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o &&
    wb_adr_i[9:2] == `CTL_EP_MODE_IDX |=> wb_dat_o[`SETUP_RX_BIT]; endproperty
  a_setup_hold: assert property (p_setup_hold) else $error("setup flag low");
  property p_rx_count; xferDone && donePid != `PID_IN |=> ##1 (tokEp != $past(doneEp, 2) ||
    inCount == 4'($past(doneBytes, 2) + `CRC_BYTES)); endproperty
  a_rx_count: assert property (p_rx_count) else $error("count not bytes+2");
  property p_reset_clean; $rose(rst_b) |-> !wb_ack_o && wb_dat_o == 32'h0 &&
    respCode == `RESP_NONE && inCount == 4'h0; endproperty
  a_reset_clean: assert property (p_reset_clean) else $error("not reset");
endmodule // usb_ep_monitor
bind usb_endpoint_status_control usb_ep_monitor u_mon (.*);
`default_nettype wire

// File: test/usb_host_model.sv
// host and serial engine side of the endpoint block, behavioural
// assumes: one task at a time; every change lands just after a rising mclk
`timescale 1ns/1ps
`default_nettype none
module usb_host_model (
  input  wire logic  mclk,
  output logic       usbBusReset,
  output logic [6:0] tokAddr,
  output logic [1:0] tokEp,
  output logic [1:0] tokPid,
  output logic       setupStart,
  output logic       ackStart,
  output logic       xferDone,
  output logic [1:0] doneEp,
  output logic [1:0] donePid,
  output logic       doneAcked,
  output logic       doneToggle,
  output logic       doneErr,
  output logic [3:0] doneBytes,
  output logic [4:0] sieFifoAddr
);
  initial begin
    {usbBusReset, setupStart, ackStart, xferDone, tokAddr, tokEp, tokPid} = 15'h0;
    {doneEp, donePid, doneAcked, doneToggle, doneErr, doneBytes, sieFifoAddr} = 16'h0;
  end
  // s: bus reset, setup data start, ack start
  task automatic pulse(input logic [2:0] s);
    @(posedge mclk);
    {usbBusReset, setupStart, ackStart} <= s;
    @(posedge mclk);
    {usbBusReset, setupStart, ackStart} <= 3'h0;
  endtask
  task automatic token(input logic [6:0] a, input logic [1:0] e, input logic [1:0] p);
    @(posedge mclk);
    {tokAddr, tokEp, tokPid} <= {a, e, p};
  endtask
  // f: acked, toggle, error; n is 0..8 data bytes
  task automatic done(input logic [1:0] e, input logic [1:0] p, input logic [2:0] f,
                      input logic [3:0] n);
    @(posedge mclk);
    xferDone <= 1'b1;
    {doneEp, donePid, doneAcked, doneToggle, doneErr, doneBytes} <= {e, p, f, n};
    @(posedge mclk);
    xferDone <= 1'b0;
    // status is not held after the event; inverted so a late sample shows
    {doneEp, donePid, doneAcked, doneToggle, doneErr, doneBytes} <= ~{e, p, f, n};
  endtask
  task automatic peek(input logic [4:0] a);
    @(posedge mclk);
    sieFifoAddr <= a;
  endtask
endmodule // usb_host_model
`default_nettype wire

// File: test/testbench.sv
// self-checking bench of the endpoint status block
// assumes: usb_ep_regs.vh on the include path, host model on the engine side
`timescale 1ns/1ps
`default_nettype none
`include "usb_ep_regs.vh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_errors++; \
  $display("Error at %0t: got %h expected %h", $time, g, e); end end
module testbench;
  logic        mclk, rst_b, wb_cyc_i, wb_stb_i, wb_we_i, sieFifoWe;
  logic [9:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i;
  logic [7:0]  sieFifoWdata, rv;
  wire  [31:0] wb_dat_o;
  wire         wb_ack_o, addrMatch, inToggle, usbBusReset, setupStart, ackStart;
  wire         xferDone, doneAcked, doneToggle, doneErr;
  wire  [1:0]  respCode, tokEp, tokPid, doneEp, donePid;
  wire  [3:0]  inCount, doneBytes;
  wire  [6:0]  tokAddr;
  wire  [4:0]  sieFifoAddr;
  wire  [7:0]  sieFifoRdata;
  int          n_errors, checked;
  // index, written, read back
  logic [23:0] rows [8] = '{24'h149f8f, 24'h168b8b, 24'h13ffcf, 24'h150808,
                            24'h12ff0f, 24'h118585, 24'h100505, 24'h20ff00};
  // mode, token kind, handshake
  logic [11:0] resp [7] = '{12'h011, 12'h016, 12'h01a, 12'h8bb, 12'h0b9, 12'h0b6, 12'h8f7};
  usb_endpoint_status_control uut (.*);
  usb_host_model host (.*);
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  // whole run is a few hundred cycles
  initial begin
    #100000;
    n_errors++;
    final_report();
  end
  task automatic final_report();
    $display("comparisons %0d, mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // ----------
  // bus master: request held until ack is seen
  // ----------
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'h3, w};
    wb_adr_i <= {idx, 2'h0};
    wb_dat_i <= {24'h0, d};
    do begin
      @(posedge mclk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    `CHK(wb_ack_o, 1'b1)
    rv = wb_dat_o[7:0];
    {wb_cyc_i, wb_stb_i} <= 2'h0;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d);
  endtask
  task automatic rd(input logic [7:0] idx, input logic [7:0] e);
    bus(1'b0, idx, 8'h0);
    `CHK(rv, e)
  endtask
  task automatic tok(input logic [6:0] a, input logic [1:0] p, input logic [1:0] e);
    host.token(a, 2'h1, p);
    @(negedge mclk);
    `CHK(respCode, e)
  endtask
  task automatic fchk(input logic [4:0] a, input logic [7:0] e);
    host.peek(a);
    @(posedge mclk);
    @(negedge mclk);
    `CHK(sieFifoRdata, e)
  endtask
  initial begin
    {rst_b, wb_cyc_i, wb_stb_i, wb_we_i, sieFifoWe, wb_adr_i, wb_dat_i, sieFifoWdata} = 55'h0;
    wb_sel_i = 4'h1;
    n_errors = 0;
    checked = 0;
    repeat (6) @(posedge mclk);
    rst_b <= 1'b1;
    for (int i = 0; i < 7; i++)
      rd(8'h10 + 8'(i), 8'h00);
    for (int i = 0; i < 8; i++) begin
      wr(rows[i][23:16], rows[i][15:8]);
      rd(rows[i][23:16], rows[i][7:0]);
    end
    $display("register table done");
    tok(7'h05, `PID_IN, `RESP_NONE);
    wr(`DEV_ADDR_IDX, 8'h85);
    for (int i = 0; i < 7; i++) begin
      wr(`FIRST_DATA_ENDPOINT_MODE_IDX, resp[i][11:4]);
      tok(7'h05, resp[i][3:2], resp[i][1:0]);
    end
    tok(7'h06, `PID_IN, `RESP_NONE);
    $display("handshakes done");
    wr(`FIRST_DATA_ENDPOINT_MODE_IDX, 8'h0b);
    host.token(7'h05, 2'h1, `PID_OUT);
    host.done(2'h1, `PID_OUT, 3'h6, 4'h3);
    rd(`FIRST_DATA_ENDPOINT_MODE_IDX, 8'h11);
    rd(`EP1_COUNT_IDX, 8'hc5);
    `CHK({inToggle, inCount}, 5'h15)
    host.done(2'h2, `PID_OUT, 3'h1, 4'h0);
    rd(`SECOND_DATA_ENDPOINT_MODE_IDX, 8'h8b);
    rd(`EP2_COUNT_IDX, 8'h02);
    wr(`CTL_EP_MODE_IDX, 8'h0b);
    host.done(2'h0, `PID_OUT, 3'h4, 4'h8);
    wr(`CTL_EP_MODE_IDX, 8'h0f);
    wr(`CTL_EP_COUNT_IDX, 8'h03);
    rd(`CTL_EP_MODE_IDX, 8'h31);
    rd(`CTL_EP_COUNT_IDX, 8'h4a);
    wr(`CTL_EP_MODE_IDX, 8'h0f);
    wr(`CTL_EP_COUNT_IDX, 8'h03);
    rd(`CTL_EP_MODE_IDX, 8'h0f);
    rd(`CTL_EP_COUNT_IDX, 8'h03);
    host.done(2'h0, `PID_IN, 3'h4, 4'h3);
    bus(1'b0, `CTL_EP_MODE_IDX, 8'h0);
    `CHK(rv[7:4], 4'h5)
    $display("endpoint events done");
    for (int i = 0; i < 3; i++) begin
      wr(`FIFO_BASE_IDX + 8'(8 * i), 8'h20 + 8'(i));
      fchk(5'(8 * i), 8'h20 + 8'(i));
    end
    host.peek(5'h08);
    sieFifoWdata <= 8'h3c;
    sieFifoWe <= 1'b1;
    @(posedge mclk);
    sieFifoWe <= 1'b0;
    rd(`FIFO_BASE_IDX + 8'h08, 8'h3c);
    fchk(5'h1f, 8'h00);
    host.pulse(3'h2);
    wr(8'hf8, 8'h5a);
    fchk(5'h10, 8'h22);
    bus(1'b0, `CTL_EP_MODE_IDX, 8'h0);
    `CHK(rv[7], 1'b1)
    wr(`CTL_EP_MODE_IDX, 8'h01);
    rd(`CTL_EP_MODE_IDX, 8'h81);
    host.pulse(3'h1);
    wr(`CTL_EP_MODE_IDX, 8'h01);
    rd(`CTL_EP_MODE_IDX, 8'h01);
    $display("setup window done");
    tok(7'h05, `PID_IN, `RESP_NAK);
    host.pulse(3'h4);
    @(negedge mclk);
    `CHK(addrMatch, 1'b0)
    rd(`DEV_ADDR_IDX, 8'h00);
    @(posedge mclk);
    rst_b <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    rd(`FIRST_DATA_ENDPOINT_MODE_IDX, 8'h00);
    rd(`CTL_EP_COUNT_IDX, 8'h00);
    $display("resets done");
    final_report();
  end
endmodule // testbench
`default_nettype wire
